// >>> logic/tfs_fault_status.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - overcurrent on either bus line sets bus error
// - lower temperature threshold sets warning bit 6
// - upper threshold sets shutdown bit 5, transmitter off
// - temperature detection only in normal mode
// - temperature events never change operating mode
// - temperature flags set summary bit 11, pin
// - shutdown holds transmitter off until status cleared
// - transmitter active too long disables it
// - time-out sets bit 7 and summary bit
// - time-out drives error pin low in normal
// - time-out cleared by read or normal entry
// - both supplies up set power-up bit 3
// - power-up bit never drives error pin
// - mode bits show current mode, but both sleep modes show standby's 00
// - bits 13/14 mirror mode select pin levels
// - bit 15 gives even parity over word
// - bus error bit 4 disables transmitter, pin
// - read or normal entry clears all entries
module tfs_fault_status
    import tfs_pkg::*;
#(
    parameter int unsigned TX_TIMEOUT_CYCLES = tfs_pkg::TX_TIMEOUT_CYCLES_DEF
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic [tfs_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [tfs_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWrEn,
    input  wire logic                       regRdEn,
    output logic      [tfs_pkg::DATA_W-1:0] regRdData,
    input  wire tfs_pkg::tfs_mode_t         opMode,
    input  wire logic                       tempWarnIn,
    input  wire logic                       tempShutIn,
    input  wire logic                       ocBusPlusSrc,
    input  wire logic                       ocBusPlusSink,
    input  wire logic                       ocBusMinusSrc,
    input  wire logic                       ocBusMinusSink,
    input  wire logic                       transmitEnablePinN,
    input  wire logic                       busGuardianEnablePin,
    input  wire logic                       transmitterSupplyOk,
    input  wire logic                       batterySupplyOk,
    output logic                            transmitterEnable,
    output logic                            errorIndicationOutputN
);
    import tfs_pkg::*;

    typedef struct packed {
        logic                powerUp;
        logic                busErr;
        logic                otShut;
        logic                otWarn;
        logic                txTimeout;
        logic                sumErr;
        logic [TX_CNT_W-1:0] txCnt;
        logic                supOkPrev;
        tfs_mode_t           modePrev;
        logic                txReq;
        logic [DATA_W-1:0]   rdData;
    } tfs_state_t;

    localparam logic [TX_CNT_W-1:0] TX_LIMIT = TX_CNT_W'(TX_TIMEOUT_CYCLES);

    tfs_state_t          cur_q;
    tfs_state_t          nxt_d;
    logic [ASYNC_W-1:0]  asyncVec;
    logic [ASYNC_W-1:0]  syncVec;
    logic                inNormal;
    logic                readable;
    logic                readStatus;
    logic                readControl;
    logic                enterNormal;
    logic                clearAll;
    logic                txActive;
    logic                setBus;
    logic                setWarn;
    logic                setShut;
    logic                setTimeout;
    logic                setPowerUp;
    logic                supOk;
    logic [1:0]          modeBits;
    logic [DATA_W-1:0]   statusWord;

    assign asyncVec[IN_TEMP_WARN]  = tempWarnIn;
    assign asyncVec[IN_TEMP_SHUT]  = tempShutIn;
    assign asyncVec[IN_OC_PLUS_SRC]  = ocBusPlusSrc;
    assign asyncVec[IN_OC_PLUS_SNK]  = ocBusPlusSink;
    assign asyncVec[IN_OC_MINUS_SRC] = ocBusMinusSrc;
    assign asyncVec[IN_OC_MINUS_SNK] = ocBusMinusSink;
    assign asyncVec[IN_TX_EN_N]    = transmitEnablePinN;
    assign asyncVec[IN_BG_EN]      = busGuardianEnablePin;
    assign asyncVec[IN_TX_SUP_OK]  = transmitterSupplyOk;
    assign asyncVec[IN_BAT_SUP_OK] = batterySupplyOk;

    // reset of the synchroniser clears both stages: all inputs read low after reset
    tfs_sync #(
        .WIDTH   (ASYNC_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (asyncVec),
        .syncOut (syncVec)
    );

    // upper bit lands on status bit 13, lower bit on status bit 14
    always_comb begin
        case (opMode)
            MODE_NORMAL:  modeBits = 2'h3;
            MODE_RX_ONLY: modeBits = 2'h1;
            MODE_STANDBY: modeBits = 2'h0;
            default:      modeBits = 2'h0;
        endcase
    end

    assign inNormal    = (opMode == MODE_NORMAL);
    // sleep modes offer no read-out, so such a read neither returns nor clears the word
    assign readable    = (opMode == MODE_NORMAL) || (opMode == MODE_RX_ONLY)
                         || (opMode == MODE_STANDBY);
    assign readStatus  = regRdEn && (regAddr == ADDR_STATUS) && readable;
    assign readControl = regRdEn && (regAddr == ADDR_CONTROL);
    assign enterNormal = inNormal && (cur_q.modePrev != MODE_NORMAL);
    assign clearAll    = readStatus || enterNormal;
    assign txActive    = inNormal && !syncVec[IN_TX_EN_N] && syncVec[IN_BG_EN];
    assign setBus      = |syncVec[IN_OC_MINUS_SNK:IN_OC_PLUS_SRC];
    assign setWarn     = inNormal && syncVec[IN_TEMP_WARN];
    assign setShut     = inNormal && syncVec[IN_TEMP_SHUT];
    // flag when the count already stands at the limit, so that the active time strictly exceeds it
    assign setTimeout  = txActive && (cur_q.txCnt == TX_LIMIT);
    assign supOk       = syncVec[IN_TX_SUP_OK] && syncVec[IN_BAT_SUP_OK];
    assign setPowerUp  = supOk && !cur_q.supOkPrev;

    // mode bits are live, never stored, so they follow any mode change
    always_comb begin
        statusWord                 = '0;
        statusWord[BIT_POWER_UP]   = cur_q.powerUp;
        statusWord[BIT_BUS_ERR]    = cur_q.busErr;
        statusWord[BIT_OT_SHUT]    = cur_q.otShut;
        statusWord[BIT_OT_WARN]    = cur_q.otWarn;
        statusWord[BIT_TX_TIMEOUT] = cur_q.txTimeout;
        statusWord[BIT_SUM_ERR]    = cur_q.sumErr;
        statusWord[BIT_MODE_EN]    = modeBits[1];
        statusWord[BIT_MODE_STBY]  = modeBits[0];
        statusWord[BIT_PARITY]     = ^statusWord[BIT_PARITY-1:0];
    end

    always_comb begin
        nxt_d           = cur_q;
        nxt_d.modePrev  = opMode;
        nxt_d.supOkPrev = supOk;
        // set wins over clear in every flag
        nxt_d.powerUp   = (cur_q.powerUp && !clearAll) || setPowerUp;
        nxt_d.busErr    = (cur_q.busErr && !clearAll) || setBus;
        nxt_d.otWarn    = (cur_q.otWarn && !clearAll) || setWarn;
        nxt_d.otShut    = (cur_q.otShut && !clearAll) || setShut;
        nxt_d.txTimeout = (cur_q.txTimeout && !clearAll) || setTimeout;
        nxt_d.sumErr    = (cur_q.sumErr && !clearAll) || setBus || setWarn
                          || setShut || setTimeout;
        if (!txActive || clearAll || cur_q.txTimeout) begin
            nxt_d.txCnt = '0;
        end else if (cur_q.txCnt != TX_LIMIT) begin
            nxt_d.txCnt = cur_q.txCnt + TX_CNT_W'(1);
        end
        if (regWrEn && (regAddr == ADDR_CONTROL)) begin
            nxt_d.txReq = regWrData[CTRL_TX_REQ];
        end
        if (readStatus) begin
            nxt_d.rdData = statusWord;
        end else if (readControl) begin
            nxt_d.rdData = {{(DATA_W-1){1'b0}}, cur_q.txReq};
        end else begin
            nxt_d.rdData = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_q          <= '0;
            cur_q.modePrev <= MODE_STANDBY;
            cur_q.txReq    <= CONTROL_RESET[CTRL_TX_REQ];
        end else begin
            cur_q          <= nxt_d;
        end
    end

    // no mode output exists: faults only gate the transmitter
    assign transmitterEnable = cur_q.txReq && inNormal && !cur_q.busErr && !cur_q.otShut
                               && !cur_q.txTimeout;
    // power-up stays out of the summary bit, so it cannot pull the pin
    assign errorIndicationOutputN = !cur_q.sumErr;
    assign regRdData = cur_q.rdData;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    busErrSet_a: assert property (
        setBus |=> cur_q.busErr && !transmitterEnable ##0 !errorIndicationOutputN)
        else $error("overcurrent did not latch bus error");

    warnOnlyNormal_a: assert property (
        $rose(cur_q.otWarn) |-> $past(opMode) == MODE_NORMAL)
        else $error("warning flag set outside normal mode");

    shutTxOff_a: assert property (
        setShut |=> cur_q.otShut && !transmitterEnable)
        else $error("shutdown did not disable transmitter");

    otPin_a: assert property (
        (cur_q.otShut || cur_q.otWarn) |-> cur_q.sumErr && !errorIndicationOutputN)
        else $error("temperature flag not shown on error pin");

    timeoutSet_a: assert property (
        txActive && cur_q.txCnt == TX_LIMIT |=> cur_q.txTimeout && cur_q.sumErr
            && !transmitterEnable)
        else $error("transmit time-out not taken");

    earlyTimeout_a: assert property (
        $rose(cur_q.txTimeout) |-> $past(cur_q.txCnt) == TX_LIMIT)
        else $error("time-out set before limit");

    clearOnRead_a: assert property (
        readStatus && !setBus && !setWarn && !setShut && !setTimeout && !setPowerUp
            |=> !cur_q.sumErr && !cur_q.txTimeout && !cur_q.powerUp && !cur_q.busErr)
        else $error("status read did not clear entries");

    powerUpQuiet_a: assert property (
        cur_q.powerUp && !cur_q.busErr && !cur_q.otShut && !cur_q.otWarn && !cur_q.txTimeout
            |-> errorIndicationOutputN)
        else $error("power-up flag drove error pin");

    evenParity_a: assert property (
        $past(readStatus) |-> ^regRdData == 1'b0)
        else $error("status word parity is odd");

    modeBits_a: assert property (
        readStatus && opMode == MODE_RX_ONLY |=> regRdData[BIT_MODE_STBY:BIT_MODE_EN] == 2'h2)
        else $error("receive-only mode bits wrong");

    modeNormal_a: assert property (
        readStatus && opMode == MODE_NORMAL |=> regRdData[BIT_MODE_STBY:BIT_MODE_EN] == 2'h3)
        else $error("normal mode bits wrong");

    modeStandby_a: assert property (
        readStatus && opMode == MODE_STANDBY |=> regRdData[BIT_MODE_STBY:BIT_MODE_EN] == 2'h0)
        else $error("standby mode bits wrong");

    sleepNoRead_a: assert property (
        regRdEn && regAddr == ADDR_STATUS
            && (opMode == MODE_SLEEP || opMode == MODE_GO_TO_SLEEP) |=> regRdData == '0)
        else $error("status word read out in a sleep mode");

    sleepKeepsFlags_a: assert property (
        regRdEn && regAddr == ADDR_STATUS && cur_q.busErr
            && (opMode == MODE_SLEEP || opMode == MODE_GO_TO_SLEEP) |=> cur_q.busErr)
        else $error("sleep-mode read cleared the status word");

    shutOnlyNormal_a: assert property (
        $rose(cur_q.otShut) |-> $past(opMode) == MODE_NORMAL)
        else $error("shutdown flag set outside normal mode");

    warnSet_a: assert property (
        setWarn |=> cur_q.otWarn && !errorIndicationOutputN)
        else $error("warning threshold not latched");

    shutHoldsOff_a: assert property (
        cur_q.otShut |-> !transmitterEnable)
        else $error("transmitter enabled while shutdown latched");

    timeoutPin_a: assert property (
        cur_q.txTimeout && opMode == MODE_NORMAL |-> !errorIndicationOutputN)
        else $error("time-out not shown on error pin");

    timeoutTxOff_a: assert property (
        cur_q.txTimeout |-> !transmitterEnable)
        else $error("transmitter enabled after time-out");

    countBound_a: assert property (
        cur_q.txCnt <= TX_LIMIT)
        else $error("active counter ran past the limit");

    idleCount_a: assert property (
        !txActive |=> cur_q.txCnt == '0)
        else $error("active counter kept running while idle");

    normalClearsTimeout_a: assert property (
        enterNormal && !setTimeout |=> !cur_q.txTimeout)
        else $error("normal entry did not clear time-out");

    powerUpSet_a: assert property (
        setPowerUp |=> cur_q.powerUp)
        else $error("supply rise did not set power-up");

    normalClearsAll_a: assert property (
        enterNormal && !setBus && !setWarn && !setShut && !setTimeout && !setPowerUp
            |=> !cur_q.busErr && !cur_q.otShut && !cur_q.otWarn && !cur_q.powerUp && !cur_q.sumErr)
        else $error("normal entry did not clear entries");

    busErrPin_a: assert property (
        cur_q.busErr |-> !errorIndicationOutputN && !transmitterEnable)
        else $error("bus error not shown or transmitter left on");

    captureWord_a: assert property (
        readStatus |=> regRdData == $past(statusWord))
        else $error("read data differs from captured word");

    sumErrSource_a: assert property (
        cur_q.sumErr |-> cur_q.busErr || cur_q.otShut || cur_q.otWarn || cur_q.txTimeout)
        else $error("summary bit set without a fault flag");
endmodule // tfs_fault_status

// >>> logic/tfs_pkg.sv
package tfs_pkg;
    // register port
    localparam int              ADDR_W         = 4;
    localparam int              DATA_W         = 16;
    localparam logic [3:0]      ADDR_STATUS    = 4'h0;
    localparam logic [3:0]      ADDR_CONTROL   = 4'h4;
    localparam logic [15:0]     CONTROL_RESET  = 16'h0001;
    localparam int              CTRL_TX_REQ    = 0;

    // status word field positions
    localparam int              BIT_POWER_UP   = 3;
    localparam int              BIT_BUS_ERR    = 4;
    localparam int              BIT_OT_SHUT    = 5;
    localparam int              BIT_OT_WARN    = 6;
    localparam int              BIT_TX_TIMEOUT = 7;
    localparam int              BIT_SUM_ERR    = 11;
    localparam int              BIT_MODE_EN    = 13;
    localparam int              BIT_MODE_STBY  = 14;
    localparam int              BIT_PARITY     = 15;

    // asynchronous input vector layout
    localparam int              IN_TEMP_WARN   = 0;
    localparam int              IN_TEMP_SHUT   = 1;
    localparam int              IN_OC_PLUS_SRC  = 2;
    localparam int              IN_OC_PLUS_SNK  = 3;
    localparam int              IN_OC_MINUS_SRC = 4;
    localparam int              IN_OC_MINUS_SNK = 5;
    localparam int              IN_TX_EN_N     = 6;
    localparam int              IN_BG_EN       = 7;
    localparam int              IN_TX_SUP_OK   = 8;
    localparam int              IN_BAT_SUP_OK  = 9;
    localparam int              ASYNC_W        = 10;

    // timing
    localparam int              CLK_MHZ        = 200;
    localparam int              TX_ACTIVE_LIMIT_NS = 650000;
    localparam int              TX_TIMEOUT_CYCLES_DEF = (TX_ACTIVE_LIMIT_NS * CLK_MHZ) / 1000;
    localparam int              TX_CNT_W       = 18;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_RX_ONLY,
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_GO_TO_SLEEP
    } tfs_mode_t;
endpackage

// >>> logic/tfs_sync.sv
`timescale 1ns/100ps
module tfs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } tfs_sync_state_t;

    tfs_sync_state_t cur_q;
    tfs_sync_state_t nxt_d;

    // stage1 feeds only stage2 to keep metastability out of the logic
    always_comb begin
        nxt_d        = cur_q;
        nxt_d.stage1 = asyncIn;
        nxt_d.stage2 = cur_q.stage1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign syncOut = cur_q.stage2;
endmodule // tfs_sync

// >>> verif/tfs_far_model.sv
`timescale 1ns/100ps
module tfs_far_model
    import tfs_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire tfs_pkg::tfs_mode_t  modeCmd,
    input  wire logic                txReq,
    output tfs_pkg::tfs_mode_t       opMode,
    output logic                     transmitEnablePinN,
    output logic                     busGuardianEnablePin
);
    // pins move only after an edge, as the controller's own flops would
    initial begin
        opMode = MODE_STANDBY;
        transmitEnablePinN = 1'h1;
        busGuardianEnablePin = 1'h0;
    end
    always @(posedge sys_clk) begin
        opMode <= modeCmd;
        transmitEnablePinN <= ~txReq;
        busGuardianEnablePin <= txReq;
    end
endmodule // tfs_far_model

// >>> verif/tfs_fault_status_test.sv
`timescale 1ns/100ps
module tfs_fault_status_test;
    import tfs_pkg::*;
    localparam int TOUT = 20;
    logic              sys_clk = 1'h0;
    logic              sys_rst = 1'h1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic              regWrEn = 1'h0;
    logic              regRdEn = 1'h0;
    logic [DATA_W-1:0] regRdData;
    tfs_mode_t         modeCmd = MODE_NORMAL;
    tfs_mode_t         opMode;
    logic              txReq = 1'h0;
    logic              txPinN;
    logic              bgPin;
    logic [5:0]        fault = '0; // warn, shut, then four current sensors
    logic [1:0]        supply = '0;
    logic              txEnable;
    logic              error_indication_output;
    int                badCount = 0;
    int                samplesChecked = 0;

    always #2.5 sys_clk = ~sys_clk;

    tfs_far_model far_u (.sys_clk(sys_clk), .modeCmd(modeCmd), .txReq(txReq), .opMode(opMode),
        .transmitEnablePinN(txPinN), .busGuardianEnablePin(bgPin));

    tfs_fault_status #(.TX_TIMEOUT_CYCLES(TOUT)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .opMode(opMode), .tempWarnIn(fault[0]), .tempShutIn(fault[1]),
        .ocBusPlusSrc(fault[2]), .ocBusPlusSink(fault[3]), .ocBusMinusSrc(fault[4]),
        .ocBusMinusSink(fault[5]), .transmitEnablePinN(txPinN), .busGuardianEnablePin(bgPin),
        .transmitterSupplyOk(supply[0]), .batterySupplyOk(supply[1]),
        .transmitterEnable(txEnable), .errorIndicationOutputN(error_indication_output));

    task automatic testDone;
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // read data is looked at only in the single cycle it stands
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        @(posedge sys_clk);
        regRdEn <= 1'h0;
        #1 chk(regRdData, exp);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge sys_clk);
        regWrEn <= 1'h0;
    endtask

    task automatic pins(input logic tx, input logic err);
        #1 chk({14'h0, txEnable, error_indication_output}, {14'h0, tx, err});
    endtask

    // two cycles wide so the pulse survives the input synchroniser
    task automatic hit(input int i);
        @(posedge sys_clk);
        fault[i] <= 1'h1;
        cyc(2);
        fault[i] <= 1'h0;
        cyc(3);
    endtask

    initial begin
        #(20000 * 5);
        badCount++;
        testDone();
    end

    initial begin
        cyc(6);
        sys_rst <= 1'h0;
        cyc(2);
        supply <= 2'h3;
        cyc(5);
        pins(1'h1, 1'h1);
        rd(ADDR_STATUS, 16'hE008);
        rd(ADDR_STATUS, 16'h6000);
        $display("power-up test done");
        for (int i = 2; i < 6; i++) begin
            hit(i);
            pins(1'h0, 1'h0);
            rd(ADDR_STATUS, 16'h6810);
            pins(1'h1, 1'h1);
        end
        $display("overcurrent test done");
        hit(0);
        pins(1'h1, 1'h0);
        rd(ADDR_STATUS, 16'h6840);
        hit(1);
        pins(1'h0, 1'h0);
        cyc(10);
        pins(1'h0, 1'h0);
        rd(ADDR_STATUS, 16'h6820);
        pins(1'h1, 1'h1);
        $display("temperature test done");
        modeCmd <= MODE_STANDBY;
        cyc(2);
        hit(0);
        hit(1);
        rd(ADDR_STATUS, 16'h0000);
        modeCmd <= MODE_SLEEP;
        cyc(2);
        hit(2);
        rd(ADDR_STATUS, 16'h0000);
        modeCmd <= MODE_GO_TO_SLEEP;
        cyc(2);
        rd(ADDR_STATUS, 16'h0000);
        modeCmd <= MODE_RX_ONLY;
        cyc(2);
        rd(ADDR_STATUS, 16'hC810);
        rd(ADDR_STATUS, 16'hC000);
        modeCmd <= MODE_NORMAL;
        cyc(2);
        $display("mode test done");
        txReq <= 1'h1;
        cyc(TOUT);
        pins(1'h1, 1'h1);
        cyc(8);
        pins(1'h0, 1'h0);
        txReq <= 1'h0;
        cyc(4);
        rd(ADDR_STATUS, 16'h6880);
        txReq <= 1'h1;
        cyc(30);
        txReq <= 1'h0;
        modeCmd <= MODE_RX_ONLY;
        cyc(3);
        modeCmd <= MODE_NORMAL;
        cyc(3);
        rd(ADDR_STATUS, 16'h6000);
        $display("time-out test done");
        wr(ADDR_CONTROL, 16'h0000);
        pins(1'h0, 1'h1);
        rd(ADDR_CONTROL, 16'h0000);
        wr(ADDR_CONTROL, 16'hFFFF);
        rd(ADDR_CONTROL, 16'h0001);
        wr(ADDR_STATUS, 16'hFFFF);
        rd(ADDR_STATUS, 16'h6000);
        rd(4'h8, 16'h0000);
        $display("register test done");
        testDone();
    end
endmodule // tfs_fault_status_test
